//--- hdl/ext_irq_pkg.sv
// Constants, register map and enumerations for the external pin interrupt block.
package ext_irq_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int unsigned PIN_COUNT  = 8;
  localparam int unsigned LOW_COUNT  = 4;
  localparam int unsigned ADDR_W     = 4;
  localparam int unsigned DATA_W     = 8;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [3:0] OFS_SENSE_LOW  = 4'h0;
  localparam logic [3:0] OFS_SENSE_HIGH = 4'h1;
  localparam logic [3:0] OFS_MASK       = 4'h2;
  localparam logic [3:0] OFS_FLAG       = 4'h3;
  localparam logic [3:0] OFS_STATUS     = 4'h4;

  // ----------------------------------------------------------------
  // Reset values and field positions
  // ----------------------------------------------------------------
  localparam logic [7:0] SENSE_LOW_RST  = 8'h00;
  localparam logic [7:0] SENSE_HIGH_RST = 8'h00;
  localparam logic [7:0] MASK_RST       = 8'h00;
  localparam logic [7:0] FLAG_RST       = 8'h00;
  localparam logic [7:0] ZERO_BYTE      = 8'h00;
  localparam int unsigned STAT_AWAKE    = 0;
  localparam int unsigned STAT_WAKE_LVL = 1;

  // ----------------------------------------------------------------
  // Sense encodings
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SENSE_LOW_LEVEL = 2'h0,
    SENSE_ANY       = 2'h1,
    SENSE_FALL      = 2'h2,
    SENSE_RISE      = 2'h3
  } sense_t;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_MHZ       = 100;
  localparam int unsigned WDT_PERIOD_US = 1;
  localparam int unsigned WDT_CYCLES    = WDT_PERIOD_US * CLK_MHZ;
  localparam int unsigned STARTUP_CYC_DEFAULT = 64;
  localparam int unsigned WAKE_SAMPLES  = 2;

  // Power-state machine, Gray coded along sleep, sample, startup, awake.
  typedef enum logic [1:0] {
    PS_AWAKE   = 2'h0,
    PS_SLEEP   = 2'h1,
    PS_SAMPLE  = 2'h3,
    PS_STARTUP = 2'h2
  } pwr_state_t;

endpackage

//--- hdl/external_pin_interrupts.sv
// External pin interrupt controller for eight pins with sleep wake-up.
//
// Overview of operation
// R1: Pin activity raises interrupts even when the pin is driven as output.
// R2: Enabled level-sensed pin keeps requesting while the pin stays low.
// R3: Upper-pin edge detection works only while the I/O clock runs.
// R4: Low level on any pin and lower-pin edges need no clock.
// R5: The I/O clock stops in every sleep mode except idle.
// R6: Power-down level wake needs the level on two watchdog samples.
// R7: Level gone before start-up ends: wake, but no level interrupt.
// R8: The source holds a low level until the current instruction ends.
// R9: Lower-pin interrupts need both global enable and the pin mask bit.
// R10: Lower sense codes: low level, reserved, async falling, async rising.
// R11: Lower sense register holds two bits per pin, pin 3 on top.
// R12: Reset selects low-level sensing on all lower pins.
// R13: Compatibility mode hides the lower sense register, keeping reset value.
// R14: Software masks, changes sense, clears flag, then unmasks.
// R15: Writing one to a pending flag clears it.
// R16: Upper sense codes: low level, any change, falling, rising edge.
// R17: Edges set the pending flag; entering the routine clears it.
// R18: Level-sensed pins keep their pending flag cleared.
// R19: Request per pin when condition or flag, mask and global enable hold.
// R20: Reserved lower sense code produces no request.
//
// Design decisions made here: strobed register access and the placing of the registers.
module external_pin_interrupts #(
  parameter int unsigned STARTUP_CYCLES = ext_irq_pkg::STARTUP_CYC_DEFAULT
) (
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       sys_rst,
  // Register port
  input  wire logic [3:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  // Pins
  input  wire logic [7:0] ext_irq_pins,
  // Core side
  input  wire logic       global_irq_enable,
  input  wire logic [7:0] irq_ack,
  input  wire logic       compat_mode,
  input  wire logic       sleep_enter,
  input  wire logic       sleep_idle,
  input  wire logic       sleep_power_down,
  output logic      [7:0] irq_req,
  output logic            wake_up,
  output logic            io_clk_run
);

  // ----------------------------------------------------------------
  // Pin sampling
  // ----------------------------------------------------------------
  // The pins are read as inputs regardless of their direction, so a
  // driven output still feeds the detectors.
  logic [7:0] pin_s;
  logic [7:0] pin_prev_q;

  pin_sync #(
    .W (ext_irq_pkg::PIN_COUNT)
  ) u_sync (
    .mclk    (mclk),
    .sys_rst (sys_rst),
    .pin_in  (ext_irq_pins), // R1
    .pin_out (pin_s)
  );

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      pin_prev_q <= 8'hff;
    end else begin
      pin_prev_q <= pin_s;
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [7:0] pin_sense_config_low_q;
  logic [7:0] pin_sense_config_high_q;
  logic [7:0] pin_irq_mask_reg_q;
  logic [7:0] pin_irq_flag_reg_q;
  logic [7:0] pin_irq_flag_reg_d;
  logic [7:0] reg_rdata_q;
  logic       wr_low;

  assign wr_low = reg_wr && (reg_addr == ext_irq_pkg::OFS_SENSE_LOW) && !compat_mode; // R13

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      pin_sense_config_low_q <= ext_irq_pkg::SENSE_LOW_RST; // R12
    end else if (wr_low) begin
      pin_sense_config_low_q <= reg_wdata; // R11
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      pin_sense_config_high_q <= ext_irq_pkg::SENSE_HIGH_RST;
    end else if (reg_wr && reg_addr == ext_irq_pkg::OFS_SENSE_HIGH) begin
      pin_sense_config_high_q <= reg_wdata;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      pin_irq_mask_reg_q <= ext_irq_pkg::MASK_RST;
    end else if (reg_wr && reg_addr == ext_irq_pkg::OFS_MASK) begin
      pin_irq_mask_reg_q <= reg_wdata;
    end
  end

  // ----------------------------------------------------------------
  // Power state and clock gating
  // ----------------------------------------------------------------
  ext_irq_pkg::pwr_state_t pwr_q;
  logic                    idle_q;
  logic                    pd_q;
  logic [15:0]             startup_cnt_q;
  logic                    samp_run;
  logic                    samp_ok;
  logic                    samp_fail;
  logic                    wake_lvl_q;
  logic                    any_wake;
  logic                    io_clk_on;
  logic                    wake_q;
  logic [7:0]              sync_evt;
  logic                    async_evt;

  assign io_clk_on = (pwr_q == ext_irq_pkg::PS_AWAKE) || idle_q; // R5
  assign samp_run  = (pwr_q == ext_irq_pkg::PS_SAMPLE);

  wake_sampler u_wake (
    .mclk      (mclk),
    .sys_rst   (sys_rst),
    .run       (samp_run),
    .level_low (any_wake),
    .qualified (samp_ok),
    .failed    (samp_fail)
  );

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      pwr_q         <= ext_irq_pkg::PS_AWAKE;
      idle_q        <= 1'b0;
      pd_q          <= 1'b0;
      startup_cnt_q <= 16'h0000;
      wake_lvl_q    <= 1'b0;
    end else begin
      case (pwr_q)
        ext_irq_pkg::PS_AWAKE: begin
          wake_lvl_q <= 1'b0;
          if (sleep_enter) begin
            pwr_q  <= ext_irq_pkg::PS_SLEEP;
            idle_q <= sleep_idle;
            pd_q   <= sleep_power_down;
          end
        end
        ext_irq_pkg::PS_SLEEP: begin
          if (any_wake && pd_q) begin
            pwr_q <= ext_irq_pkg::PS_SAMPLE; // R6
          end else if (any_wake || async_evt || (idle_q && |sync_evt)) begin
            pwr_q         <= ext_irq_pkg::PS_STARTUP; // R4
            startup_cnt_q <= 16'h0000;
          end
        end
        ext_irq_pkg::PS_SAMPLE: begin
          if (samp_ok) begin
            pwr_q         <= ext_irq_pkg::PS_STARTUP; // R6
            startup_cnt_q <= 16'h0000;
            wake_lvl_q    <= 1'b1;
          end else if (samp_fail) begin
            pwr_q <= ext_irq_pkg::PS_SLEEP;
          end
        end
        ext_irq_pkg::PS_STARTUP: begin
          if (startup_cnt_q == 16'(STARTUP_CYCLES - 1)) begin
            // A level that vanished during start-up still wakes the core.
            pwr_q  <= ext_irq_pkg::PS_AWAKE; // R7
            idle_q <= 1'b0;
            pd_q   <= 1'b0;
          end else begin
            startup_cnt_q <= startup_cnt_q + 16'h0001;
          end
        end
        default: begin
          pwr_q <= ext_irq_pkg::PS_AWAKE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Per-pin detection
  // ----------------------------------------------------------------
  logic [7:0] level_hit;
  logic [7:0] edge_hit;
  logic [7:0] is_level;
  logic [7:0] req_d;

  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_pin
      logic [1:0] sel;
      logic       fell;
      logic       rose;
      if (g < 4) begin : g_low
        assign sel = pin_sense_config_low_q[2*g+1:2*g]; // R11
      end else begin : g_high
        assign sel = pin_sense_config_high_q[2*(g-4)+1:2*(g-4)];
      end
      assign fell        = pin_prev_q[g] && !pin_s[g];
      assign rose        = !pin_prev_q[g] && pin_s[g];
      assign is_level[g] = (sel == ext_irq_pkg::SENSE_LOW_LEVEL);
      assign level_hit[g] = is_level[g] && !pin_s[g]; // R2
      if (g < 4) begin : g_async
        // Lower-pin edges are registered without depending on the I/O clock gate.
        assign edge_hit[g] = ((sel == ext_irq_pkg::SENSE_FALL) && fell) ||
                             ((sel == ext_irq_pkg::SENSE_RISE) && rose); // R10 R20 R4
        assign sync_evt[g] = 1'b0;
      end else begin : g_sync
        assign sync_evt[g] = ((sel == ext_irq_pkg::SENSE_ANY) && (fell || rose)) ||
                             ((sel == ext_irq_pkg::SENSE_FALL) && fell) ||
                             ((sel == ext_irq_pkg::SENSE_RISE) && rose); // R16
        assign edge_hit[g] = sync_evt[g] && io_clk_on; // R3
      end
    end
  endgenerate

  assign async_evt = |edge_hit[3:0];
  assign any_wake  = |level_hit;

  // ----------------------------------------------------------------
  // Pending flags
  // ----------------------------------------------------------------
  always_comb begin
    pin_irq_flag_reg_d = pin_irq_flag_reg_q;
    if (reg_wr && reg_addr == ext_irq_pkg::OFS_FLAG) begin
      pin_irq_flag_reg_d = pin_irq_flag_reg_d & ~reg_wdata; // R15
    end
    pin_irq_flag_reg_d = pin_irq_flag_reg_d & ~irq_ack; // R17
    // A new edge wins over a clear in the same cycle.
    pin_irq_flag_reg_d = pin_irq_flag_reg_d | edge_hit; // R17
    pin_irq_flag_reg_d = pin_irq_flag_reg_d & ~is_level; // R18
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      pin_irq_flag_reg_q <= ext_irq_pkg::FLAG_RST;
    end else begin
      pin_irq_flag_reg_q <= pin_irq_flag_reg_d;
    end
  end

  // ----------------------------------------------------------------
  // Requests
  // ----------------------------------------------------------------
  // The level request only reaches the core when the level survived
  // start-up, which keeps a noise blip from firing a handler.
  always_comb begin
    req_d = (level_hit | pin_irq_flag_reg_q) & pin_irq_mask_reg_q; // R19
    if (!global_irq_enable || pwr_q != ext_irq_pkg::PS_AWAKE) begin
      req_d = ext_irq_pkg::ZERO_BYTE; // R9
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      irq_req <= ext_irq_pkg::ZERO_BYTE;
      wake_q  <= 1'b0;
    end else begin
      irq_req <= req_d; // R2 R19
      wake_q  <= (pwr_q == ext_irq_pkg::PS_STARTUP) &&
                 (startup_cnt_q == 16'(STARTUP_CYCLES - 1));
    end
  end

  assign wake_up = wake_q;

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      io_clk_run <= 1'b1;
    end else begin
      io_clk_run <= io_clk_on; // R5
    end
  end

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      reg_rdata_q <= ext_irq_pkg::ZERO_BYTE;
    end else if (reg_rd) begin
      case (reg_addr)
        ext_irq_pkg::OFS_SENSE_LOW:
          reg_rdata_q <= compat_mode ? ext_irq_pkg::ZERO_BYTE : pin_sense_config_low_q; // R13
        ext_irq_pkg::OFS_SENSE_HIGH: reg_rdata_q <= pin_sense_config_high_q;
        ext_irq_pkg::OFS_MASK:       reg_rdata_q <= pin_irq_mask_reg_q;
        ext_irq_pkg::OFS_FLAG:       reg_rdata_q <= pin_irq_flag_reg_q;
        ext_irq_pkg::OFS_STATUS: begin
          reg_rdata_q <= ext_irq_pkg::ZERO_BYTE;
          reg_rdata_q[ext_irq_pkg::STAT_AWAKE]    <= (pwr_q == ext_irq_pkg::PS_AWAKE);
          reg_rdata_q[ext_irq_pkg::STAT_WAKE_LVL] <= wake_lvl_q;
        end
        default: reg_rdata_q <= ext_irq_pkg::ZERO_BYTE;
      endcase
    end else begin
      reg_rdata_q <= ext_irq_pkg::ZERO_BYTE;
    end
  end

  assign reg_rdata = reg_rdata_q;

endmodule

//--- hdl/pin_sync.sv
// Three-stage synchroniser with agreement filter for the interrupt pins.
module pin_sync #(
  parameter int unsigned W = 8
) (
  // Clock and reset
  input  wire logic         mclk,
  input  wire logic         sys_rst,
  // Pins and filtered result
  input  wire logic [W-1:0] pin_in,
  output logic      [W-1:0] pin_out
);

  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  logic [W-1:0] out_q;

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      s1_q  <= '1;
      s2_q  <= '1;
      s3_q  <= '1;
      out_q <= '1;
    end else begin
      s1_q <= pin_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      // A change counts only once the second and third stage agree.
      for (int i = 0; i < W; i++) begin
        if (s2_q[i] == s3_q[i]) begin
          out_q[i] <= s3_q[i];
        end
      end
    end
  end

  assign pin_out = out_q;

endmodule

//--- hdl/wake_sampler.sv
// Watchdog-tick sampler that qualifies a level wake-up by two samples.
module wake_sampler (
  // Clock and reset
  input  wire logic mclk,
  input  wire logic sys_rst,
  // Control
  input  wire logic run,
  input  wire logic level_low,
  // Result
  output logic      qualified,
  output logic      failed
);

  logic [7:0] tick_cnt_q;
  logic [1:0] hits_q;
  logic       qual_q;
  logic       fail_q;
  logic       tick;

  assign tick = (tick_cnt_q == 8'(ext_irq_pkg::WDT_CYCLES - 1));

  always_ff @(posedge mclk) begin
    if (sys_rst || !run) begin
      tick_cnt_q <= 8'h00;
    end else if (tick) begin
      tick_cnt_q <= 8'h00;
    end else begin
      tick_cnt_q <= tick_cnt_q + 8'h01;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst || !run) begin
      hits_q <= 2'h0;
      qual_q <= 1'b0;
      fail_q <= 1'b0;
    end else if (tick && !qual_q && !fail_q) begin
      if (!level_low) begin
        fail_q <= 1'b1;
      end else if (hits_q == 2'(ext_irq_pkg::WAKE_SAMPLES - 1)) begin
        qual_q <= 1'b1;
      end else begin
        hits_q <= hits_q + 2'h1;
      end
    end
  end

  assign qualified = qual_q;
  assign failed    = fail_q;

endmodule

//--- testbench/board_pins.sv
// Board-side driver of the eight interrupt pins.
module board_pins (
  // Requested levels
  input  wire logic [7:0] drive_lvl,
  // Pins
  output wire logic [7:0] ext_irq_pins
);
  timeunit 1ns;
  timeprecision 1ps;
  // Edges land off the clock grid, so the synchroniser sees truly async input.
  // This driver also stands for the device's own output buffer on the pin.
  assign #3 ext_irq_pins = drive_lvl;
endmodule

//--- testbench/ext_irq_sva.sv
// Port checker for the external pin interrupt block.
module ext_irq_sva #(
  parameter int unsigned STARTUP_CYCLES = 64
) (
  // Clock and reset
  input wire logic       mclk,
  input wire logic       sys_rst,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  // Pins and core side
  input wire logic [7:0] ext_irq_pins,
  input wire logic       global_irq_enable,
  input wire logic [7:0] irq_ack,
  input wire logic       compat_mode,
  input wire logic       sleep_enter,
  input wire logic       sleep_idle,
  input wire logic       sleep_power_down,
  input wire logic [7:0] irq_req,
  input wire logic       wake_up,
  input wire logic       io_clk_run
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  // Three low cycles allow for the registered request output irq_req.
  gate_global_a: assert property ((!global_irq_enable) [*3] |-> irq_req == 8'h00)
    else $error("request while global enable low");
  hide_sense_a: assert property (reg_rd && compat_mode &&
    reg_addr == ext_irq_pkg::OFS_SENSE_LOW |=> reg_rdata == 8'h00)
    else $error("low sense register visible in compat mode");
  unmapped_read_a: assert property (reg_rd && reg_addr > 4'h4 |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  idle_rdata_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data outside read cycle");
  wake_pulse_a: assert property (wake_up |=> !wake_up)
    else $error("wake pulse longer than one cycle");
  deep_stop_a: assert property (sleep_enter && !sleep_idle |-> ##[1:3] !io_clk_run)
    else $error("io clock kept in deep sleep");
  idle_clock_a: assert property (sleep_enter && sleep_idle |=> io_clk_run [*2])
    else $error("io clock stopped in idle");
  asleep_quiet_a: assert property (!io_clk_run ##1 !io_clk_run |-> irq_req == 8'h00)
    else $error("request while asleep");
  wake_clock_a: assert property (wake_up |-> ##[0:2] io_clk_run)
    else $error("io clock not back after wake");
endmodule

bind external_pin_interrupts ext_irq_sva #(.STARTUP_CYCLES(STARTUP_CYCLES)) ext_irq_sva_inst (
  .mclk(mclk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ext_irq_pins(ext_irq_pins),
  .global_irq_enable(global_irq_enable), .irq_ack(irq_ack), .compat_mode(compat_mode),
  .sleep_enter(sleep_enter), .sleep_idle(sleep_idle), .sleep_power_down(sleep_power_down),
  .irq_req(irq_req), .wake_up(wake_up), .io_clk_run(io_clk_run)
);

//--- testbench/testbench.sv
// Self-checking bench for the external pin interrupt block.
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned STARTUP = 200;
  logic       mclk              = 1'h0;
  logic       sys_rst           = 1'h1;
  logic [3:0] reg_addr          = 4'h0;
  logic [7:0] reg_wdata         = 8'h00;
  logic       reg_wr            = 1'h0;
  logic       reg_rd            = 1'h0;
  logic [7:0] drive_lvl         = 8'hFF;
  logic       global_irq_enable = 1'h0;
  logic [7:0] irq_ack           = 8'h00;
  logic       compat_mode       = 1'h0;
  logic       sleep_enter       = 1'h0;
  logic       sleep_idle        = 1'h0;
  logic       sleep_power_down  = 1'h0;
  logic [7:0] reg_rdata;
  logic [7:0] ext_irq_pins;
  logic [7:0] irq_req;
  logic       wake_up;
  logic       io_clk_run;
  logic       seen;
  int         error_cnt   = 0;
  int         checks_done = 0;
  int         cycles      = 0;

  board_pins board_pins_inst (.drive_lvl(drive_lvl), .ext_irq_pins(ext_irq_pins));
  external_pin_interrupts #(.STARTUP_CYCLES(STARTUP)) external_pin_interrupts_inst (
    .mclk(mclk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ext_irq_pins(ext_irq_pins),
    .global_irq_enable(global_irq_enable), .irq_ack(irq_ack), .compat_mode(compat_mode),
    .sleep_enter(sleep_enter), .sleep_idle(sleep_idle), .sleep_power_down(sleep_power_down),
    .irq_req(irq_req), .wake_up(wake_up), .io_clk_run(io_clk_run)
  );

  always #5 mclk = ~mclk;

  // ----
  // Helpers
  // ----
  task automatic report_and_stop();
    $display("errors %0d, checks %0d", error_cnt, checks_done);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // The ceiling is about thirteen times the expected run length.
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      error_cnt++;
      report_and_stop();
    end
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      error_cnt++;
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_wr <= 1'h1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'h0;
  endtask

  // Read data stand only in the cycle after the strobe, so sample just there.
  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge mclk);
    reg_rd <= 1'h1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'h0;
    #1 chk(reg_rdata, exp);
  endtask

  task automatic pins(input logic [7:0] v);
    @(posedge mclk);
    drive_lvl <= v;
  endtask

  task automatic wait_wake(input int lim);
    seen = 1'h0;
    for (int i = 0; i < lim && !seen; i++) begin
      @(posedge mclk);
      #1 seen = (wake_up === 1'h1);
    end
  endtask

  task automatic sleep(input logic idle);
    @(posedge mclk);
    sleep_enter <= 1'h1;
    sleep_idle <= idle;
    sleep_power_down <= !idle;
    @(posedge mclk);
    sleep_enter <= 1'h0;
    tick(3);
    chk(io_clk_run, idle);
  endtask

  // Mask, change sense, clear flags, then apply the pin step.
  task automatic edge_case(input logic [3:0] a, input logic [7:0] sense,
                           input logic [7:0] pa, input logic [7:0] pb, input logic [7:0] exp);
    wr(ext_irq_pkg::OFS_MASK, 8'h00);
    pins(pa);
    tick(8);
    wr(a, sense);
    wr(ext_irq_pkg::OFS_FLAG, 8'hFF);
    pins(pb);
    tick(8);
    rd(ext_irq_pkg::OFS_FLAG, exp);
  endtask

  // ----
  // Main sequence
  // ----
  initial begin
    tick(6);
    sys_rst <= 1'h0;
    for (int i = 0; i < 6; i++) rd(4'(i), (i == 4) ? 8'h01 : 8'h00);
    compat_mode <= 1'h1;
    wr(ext_irq_pkg::OFS_SENSE_LOW, 8'hFF);
    rd(ext_irq_pkg::OFS_SENSE_LOW, 8'h00);
    compat_mode <= 1'h0;
    rd(ext_irq_pkg::OFS_SENSE_LOW, 8'h00);
    wr(ext_irq_pkg::OFS_SENSE_LOW, 8'hE4);
    rd(ext_irq_pkg::OFS_SENSE_LOW, 8'hE4);
    global_irq_enable <= 1'h1;
    wr(ext_irq_pkg::OFS_MASK, 8'h01);
    pins(8'hFE);
    tick(40);
    chk(irq_req, 8'h01);
    rd(ext_irq_pkg::OFS_FLAG, 8'h00);
    global_irq_enable <= 1'h0;
    tick(4);
    chk(irq_req, 8'h00);
    global_irq_enable <= 1'h1;
    pins(8'hFF);
    tick(8);
    chk(irq_req, 8'h00);
    edge_case(ext_irq_pkg::OFS_SENSE_LOW, 8'h78, 8'hFB, 8'hF5, 8'h06);
    edge_case(ext_irq_pkg::OFS_SENSE_HIGH, 8'h39, 8'hBF, 8'hCF, 8'h70);
    wr(ext_irq_pkg::OFS_MASK, 8'h70);
    tick(3);
    chk(irq_req, 8'h70);
    @(posedge mclk);
    irq_ack <= 8'h10;
    @(posedge mclk);
    irq_ack <= 8'h00;
    tick(3);
    chk(irq_req, 8'h60);
    wr(ext_irq_pkg::OFS_FLAG, 8'h20);
    tick(3);
    chk(irq_req, 8'h40);
    rd(ext_irq_pkg::OFS_FLAG, 8'h40);
    pins(8'hFF);
    tick(8);
    wr(ext_irq_pkg::OFS_FLAG, 8'hFF);
    wr(ext_irq_pkg::OFS_MASK, 8'h01);
    sleep(1'h0);
    pins(8'hFE);
    tick(50);
    pins(8'hFF);
    wait_wake(400);
    chk(seen, 1'h0);
    pins(8'hFE);
    tick(250);
    pins(8'hFF);
    wait_wake(400);
    chk(seen, 1'h1);
    tick(3);
    chk(irq_req, 8'h00);
    sleep(1'h0);
    pins(8'hFE);
    wait_wake(600);
    chk(seen, 1'h1);
    tick(3);
    chk(irq_req, 8'h01);
    pins(8'hFF);
    sleep(1'h1);
    tick(20);
    chk(io_clk_run, 1'h1);
    sys_rst <= 1'h1;
    tick(3);
    sys_rst <= 1'h0;
    rd(ext_irq_pkg::OFS_STATUS, 8'h01);
    rd(ext_irq_pkg::OFS_SENSE_LOW, 8'h00);
    report_and_stop();
  end
endmodule
